// *** port_pkg.sv ***
// Operation
// R1 - port 6 latch writes land first in a holding buffer
// R2 - with the select bit clear, the buffered bit moves into the latch
// R3 - with the select bit set, the value waits in the buffer until it clears
// R4 - reading the port 6 latch returns the latch itself, not the buffer
// R5 - the clock output pin never behaves as open drain
// R6 - the clock output keeps running while the chip is held in reset
// R7 - register bits of unbonded pins still store writes and read back
// R8 - after reset the ready pin is low-speed io; the core then sees low
// R9 - software should set unbonded pins as push-pull outputs with fixed latch
// R10 - software should treat unbonded latch bits as reserved, no branching
// R11 - weak pull-ups stay on until the port's select register is first written
// R12 - buffer-to-latch transfer completes one clock after write or clear
package port_pkg;
   localparam logic [11:0] port2_latch_addr = 12'h000;
   localparam logic [11:0] port2_select_addr = 12'h004;
   localparam logic [11:0] port2_open_drain_addr = 12'h008;
   localparam logic [11:0] port2_pin_addr = 12'h00C;
   localparam logic [11:0] port6_latch_addr = 12'h010;
   localparam logic [11:0] port6_select_addr = 12'h014;
   localparam logic [11:0] port6_open_drain_addr = 12'h018;
   localparam logic [11:0] port6_pin_addr = 12'h01C;
   localparam logic [11:0] ready_select_addr = 12'h020;
   localparam logic [11:0] status_addr = 12'h024;
   localparam int port_width = 8;
   localparam int core_clock_output_pin_bit = 7;
   localparam logic [7:0] latch_reset = 8'hFF;
   localparam logic [7:0] select_reset = 8'h00;
   localparam logic [7:0] open_drain_reset = 8'h00;
   localparam int status_pullup2_bit = 0;
   localparam int status_pullup6_bit = 1;
   localparam int status_pending_pos = 8;
endpackage

// *** port_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; a change is taken once stages two and three agree
module port_sync (
   input wire logic ref_clk, // core clock
   input wire logic nrst, // async reset, active low
   input wire logic [7:0] pin_in, // raw pin levels
   output logic [7:0] pin_sync // filtered levels
);
   logic [7:0] s1;
   logic [7:0] s2;
   logic [7:0] s3;
   logic [7:0] next_sync;

   // accept only where the two later stages agree
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         next_sync[i] = (s2[i] == s3[i]) ? s3[i] : pin_sync[i];
      end
   end

   // stage one is read only by stage two
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s1 <= 8'h00;
         s2 <= 8'h00;
         s3 <= 8'h00;
         pin_sync <= 8'h00;
      end else begin
         s1 <= pin_in;
         s2 <= s1;
         s3 <= s2;
         pin_sync <= next_sync;
      end
   end
endmodule
`default_nettype wire

// *** port_block.sv ***
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module port_block (
   input wire logic ref_clk, // core clock, 100 MHz
   input wire logic nrst, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic [7:0] port2_in, // port 2 pin levels
   output logic [7:0] port2_out, // port 2 pin drive value
   output logic [7:0] port2_oe, // port 2 pin drive enable
   output logic [7:0] port2_pullup, // port 2 weak pull-up enable
   input wire logic [7:0] port6_in, // port 6 pin levels
   output logic [7:0] port6_out, // port 6 pin drive value
   output logic [7:0] port6_oe, // port 6 pin drive enable
   output logic [7:0] port6_pullup, // port 6 weak pull-up enable
   input wire logic [7:0] port6_func_out, // port 6 special-function values
   input wire logic core_clk_div, // core clock output source
   input wire logic ready_pin_in, // bus ready pin
   output logic bus_ready_int // ready seen by the bus logic
);
   typedef enum logic [1:0] {
      idle_st = 2'b01,
      access_st = 2'b10
   } bus_st_t;

   bus_st_t st, next_st;
   logic [7:0] p2_latch, next_p2_latch;
   logic [7:0] p2_sel, next_p2_sel;
   logic [7:0] p2_od, next_p2_od;
   logic [7:0] p6_latch, next_p6_latch;
   logic [7:0] p6_buf, next_p6_buf;
   logic [7:0] p6_pend, next_p6_pend;
   logic [7:0] p6_sel, next_p6_sel;
   logic [7:0] p6_od, next_p6_od;
   logic ready_sel, next_ready_sel;
   logic pull2, next_pull2;
   logic pull6, next_pull6;
   logic [31:0] next_prdata;
   logic [7:0] p2_sync;
   logic [7:0] p6_sync;
   logic [7:0] rdy_sync;
   logic wr_en;
   logic rd_en;
   logic [7:0] drain_now;
   logic [7:0] held_now;

   // open-drain drive: only a low is driven
   function automatic logic [7:0] drive_en(input logic [7:0] od, input logic [7:0] val);
      drive_en = ~od | ~val;
   endfunction

   port_sync u_sync2 (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .pin_in(port2_in),
      .pin_sync(p2_sync)
   );
   port_sync u_sync6 (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .pin_in(port6_in),
      .pin_sync(p6_sync)
   );
   port_sync u_sync_rdy (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .pin_in({7'h00, ready_pin_in}),
      .pin_sync(rdy_sync)
   );

   // no wait states: setup, then a single access cycle with pready high
   assign pready = (st == access_st);
   assign pslverr = 1'b0;
   assign wr_en = psel && penable && pready && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   // pending bits split by their select: free ones drain, selected ones wait
   assign drain_now = p6_pend & ~p6_sel;
   assign held_now = p6_pend & p6_sel;

   always_comb begin
      case (st)
         idle_st: next_st = (psel && !penable) ? access_st : idle_st;
         access_st: next_st = idle_st;
         default: next_st = idle_st;
      endcase
   end

   // register writes; every bit stores, bonded or not
   always_comb begin
      next_p2_latch = p2_latch;
      next_p2_sel = p2_sel;
      next_p2_od = p2_od;
      next_p6_sel = p6_sel;
      next_p6_od = p6_od;
      next_ready_sel = ready_sel;
      next_pull2 = pull2;
      next_pull6 = pull6;
      next_p6_buf = p6_buf;
      // drained bits drop out; a new write below marks all again and wins
      next_p6_pend = held_now; // R3
      if (wr_en) begin
         case (paddr)
            port_pkg::port2_latch_addr: next_p2_latch = pwdata[7:0]; // R7
            port_pkg::port2_select_addr: begin
               next_p2_sel = pwdata[7:0]; // R7
               next_pull2 = 1'b0; // R11
            end
            port_pkg::port2_open_drain_addr: next_p2_od = pwdata[7:0]; // R7
            port_pkg::port6_latch_addr: begin
               next_p6_buf = pwdata[7:0]; // R1
               next_p6_pend = 8'hFF; // R1
            end
            port_pkg::port6_select_addr: begin
               next_p6_sel = pwdata[7:0];
               next_pull6 = 1'b0; // R11
            end
            port_pkg::port6_open_drain_addr: next_p6_od = pwdata[7:0]; // R7
            port_pkg::ready_select_addr: next_ready_sel = pwdata[0];
            default: next_ready_sel = ready_sel;
         endcase
      end
   end

   // drain pending bits whose select is clear; held bits wait in the buffer
   always_comb begin
      next_p6_latch = p6_latch;
      for (int i = 0; i < 8; i++) begin
         if (drain_now[i]) begin
            next_p6_latch[i] = p6_buf[i]; // R2 R12
         end
      end
   end

   // read mux, captured in setup so prdata is a register at the access cycle
   always_comb begin
      next_prdata = prdata;
      if (rd_en) begin
         case (paddr)
            port_pkg::port2_latch_addr: next_prdata = {24'h00_0000, p2_latch};
            port_pkg::port2_select_addr: next_prdata = {24'h00_0000, p2_sel};
            port_pkg::port2_open_drain_addr: next_prdata = {24'h00_0000, p2_od};
            port_pkg::port2_pin_addr: next_prdata = {24'h00_0000, p2_sync};
            port_pkg::port6_latch_addr: next_prdata = {24'h00_0000, p6_latch}; // R4
            port_pkg::port6_select_addr: next_prdata = {24'h00_0000, p6_sel};
            port_pkg::port6_open_drain_addr: next_prdata = {24'h00_0000, p6_od};
            port_pkg::port6_pin_addr: next_prdata = {24'h00_0000, p6_sync};
            port_pkg::ready_select_addr: next_prdata = {31'h0000_0000, ready_sel};
            port_pkg::status_addr: begin
               next_prdata = 32'h0000_0000;
               next_prdata[port_pkg::status_pullup2_bit] = pull2; // R11
               next_prdata[port_pkg::status_pullup6_bit] = pull6; // R11
               next_prdata[port_pkg::status_pending_pos +: 8] = p6_pend; // R3
            end
            default: next_prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st <= idle_st;
         p2_latch <= port_pkg::latch_reset;
         p2_sel <= port_pkg::select_reset;
         p2_od <= port_pkg::open_drain_reset;
         p6_latch <= port_pkg::latch_reset;
         p6_buf <= port_pkg::latch_reset;
         p6_pend <= 8'h00;
         p6_sel <= port_pkg::select_reset;
         p6_od <= port_pkg::open_drain_reset;
         ready_sel <= 1'b0; // R8
         pull2 <= 1'b1; // R11
         pull6 <= 1'b1; // R11
         prdata <= 32'h0000_0000;
      end else begin
         st <= next_st;
         p2_latch <= next_p2_latch;
         p2_sel <= next_p2_sel;
         p2_od <= next_p2_od;
         p6_latch <= next_p6_latch;
         p6_buf <= next_p6_buf;
         p6_pend <= next_p6_pend;
         p6_sel <= next_p6_sel;
         p6_od <= next_p6_od;
         ready_sel <= next_ready_sel;
         pull2 <= next_pull2;
         pull6 <= next_pull6;
         prdata <= next_prdata;
      end
   end

   // pin drive: clock output bypasses reset and open drain
   always_comb begin
      port2_out = p2_latch;
      port2_oe = drive_en(p2_od, p2_latch) & ~p2_sel;
      port2_out[port_pkg::core_clock_output_pin_bit] = core_clk_div; // R6
      port2_oe[port_pkg::core_clock_output_pin_bit] = 1'b1; // R5 R6
      port6_out = (p6_sel & port6_func_out) | (~p6_sel & p6_latch);
      port6_oe = drive_en(p6_od, port6_out);
      port2_pullup = {8{pull2}};
      port6_pullup = {8{pull6}};
   end

   // low-speed io ready pin feeds a constant low inward
   assign bus_ready_int = ready_sel ? rdy_sync[0] : 1'b0; // R8

   property p_latch_hidden;
      @(posedge ref_clk) disable iff (!nrst)
      (wr_en && paddr == port_pkg::port6_latch_addr) |=> (p6_latch == $past(p6_latch));
   endproperty
   a_latch_hidden: assert property (p_latch_hidden) else $error("latch changed on write"); // R1

   property p_transfer;
      @(posedge ref_clk) disable iff (!nrst)
      (p6_pend[0] && !p6_sel[0]) |=> (p6_latch[0] == $past(p6_buf[0]) && !p6_pend[0]);
   endproperty
   a_transfer: assert property (p_transfer) else $error("transfer missed"); // R2 R12

   property p_hold;
      @(posedge ref_clk) disable iff (!nrst)
      (p6_pend[1] && p6_sel[1] && !wr_en) |=> (p6_latch[1] == $past(p6_latch[1]) && p6_pend[1]);
   endproperty
   a_hold: assert property (p_hold) else $error("held bit leaked"); // R3

   property p_read_latch;
      @(posedge ref_clk) disable iff (!nrst)
      (rd_en && paddr == port_pkg::port6_latch_addr) |=> (prdata[7:0] == $past(p6_latch));
   endproperty
   a_read_latch: assert property (p_read_latch) else $error("read not latch"); // R4

   property p_no_od;
      @(posedge ref_clk) disable iff (!nrst)
      p2_od[port_pkg::core_clock_output_pin_bit] |-> port2_oe[port_pkg::core_clock_output_pin_bit];
   endproperty
   a_no_od: assert property (p_no_od) else $error("clock pin open drain"); // R5

   property p_clk_follow;
      @(posedge ref_clk) port2_out[port_pkg::core_clock_output_pin_bit] == core_clk_div;
   endproperty
   a_clk_follow: assert property (p_clk_follow) else $error("clock output lost"); // R6

   property p_store;
      @(posedge ref_clk) disable iff (!nrst)
      (wr_en && paddr == port_pkg::port2_latch_addr) |=> (p2_latch == $past(pwdata[7:0]));
   endproperty
   a_store: assert property (p_store) else $error("write not stored"); // R7

   property p_ready_low;
      @(posedge ref_clk) disable iff (!nrst)
      !ready_sel |-> !bus_ready_int;
   endproperty
   a_ready_low: assert property (p_ready_low) else $error("ready not low"); // R8

   property p_pullup;
      @(posedge ref_clk) disable iff (!nrst)
      (wr_en && paddr == port_pkg::port6_select_addr) |=> !pull6 ##1 !pull6;
   endproperty
   a_pullup: assert property (p_pullup) else $error("pull-up stayed on"); // R11

   property p_pend_set;
      @(posedge ref_clk) disable iff (!nrst)
      (wr_en && paddr == port_pkg::port6_latch_addr)
         |=> (p6_pend == 8'hFF && p6_buf == $past(pwdata[7:0]));
   endproperty
   a_pend_set: assert property (p_pend_set) else $error("write not buffered"); // R1

   property p_latch_quiet;
      @(posedge ref_clk) disable iff (!nrst)
      1'b1 |=> (((p6_latch ^ $past(p6_latch)) & ~$past(drain_now)) == 8'h00);
   endproperty
   a_latch_quiet: assert property (p_latch_quiet) else $error("latch moved outside transfer"); // R1

   property p_transfer_all;
      @(posedge ref_clk) disable iff (!nrst)
      (|drain_now) |=> (((p6_latch ^ $past(p6_buf)) & $past(drain_now)) == 8'h00);
   endproperty
   a_transfer_all: assert property (p_transfer_all) else $error("free bit not moved"); // R2 R12

   property p_hold_all;
      @(posedge ref_clk) disable iff (!nrst)
      (|held_now) |=> ((~p6_pend & $past(held_now)) == 8'h00);
   endproperty
   a_hold_all: assert property (p_hold_all) else $error("held bit dropped"); // R3

   property p_pull6_keep;
      @(posedge ref_clk) disable iff (!nrst)
      (pull6 && !(wr_en && paddr == port_pkg::port6_select_addr)) |=> pull6;
   endproperty
   a_pull6_keep: assert property (p_pull6_keep) else $error("pull-up dropped early"); // R11

   property p_clk_drive;
      @(posedge ref_clk) port2_oe[port_pkg::core_clock_output_pin_bit];
   endproperty
   a_clk_drive: assert property (p_clk_drive) else $error("clock pin not driven"); // R6

   property p_store_od;
      @(posedge ref_clk) disable iff (!nrst)
      (wr_en && paddr == port_pkg::port6_open_drain_addr) |=> (p6_od == $past(pwdata[7:0]));
   endproperty
   a_store_od: assert property (p_store_od) else $error("open-drain not stored"); // R7

   c_held: cover property (@(posedge ref_clk) p6_pend[0] && p6_sel[0] ##1 !p6_sel[0]);
   c_write6: cover property (@(posedge ref_clk) wr_en && paddr == port_pkg::port6_latch_addr);
   c_read6: cover property (@(posedge ref_clk) rd_en && paddr == port_pkg::port6_latch_addr);
   c_ready: cover property (@(posedge ref_clk) ready_sel && bus_ready_int);
endmodule
`default_nettype wire

// *** port_block_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, (got), (exp)); end end
module port_block_tb_top;
   // clock starts at a defined level so no false edge is seen at time zero
   logic ref_clk = 1'b0;
   logic core_clk_div = 1'b0;
   logic nrst, psel, penable, pwrite, pready, pslverr, ready_pin_in;
   logic bus_ready_int;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] port2_in, port2_out, port2_oe, port2_pullup;
   logic [7:0] port6_in, port6_out, port6_oe, port6_pullup, port6_func_out;
   int bad_count = 0;
   int samples_checked = 0;
   port_block port_block_inst (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .port2_in(port2_in), .port2_out(port2_out), .port2_oe(port2_oe),
      .port2_pullup(port2_pullup), .port6_in(port6_in), .port6_out(port6_out),
      .port6_oe(port6_oe), .port6_pullup(port6_pullup), .port6_func_out(port6_func_out),
      .core_clk_div(core_clk_div), .ready_pin_in(ready_pin_in), .bus_ready_int(bus_ready_int));
   // 100 MHz core clock
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   // clock output source toggles every rising edge so a stuck copy is caught
   always @(posedge ref_clk) core_clk_div <= ~core_clk_div;
   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      // no cycle count assumed; the watchdog ends a hung wait
      while (pready !== 1'b1) begin
         @(posedge ref_clk);
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   // clock output and pull-ups while reset is held
   task automatic t_reset;
      repeat (3) begin
         @(negedge ref_clk);
         `CHK(port2_out[7], core_clk_div)
         `CHK(port2_oe[7], 1'b1)
      end
      `CHK(port2_pullup, 8'hFF)
      `CHK(port6_pullup, 8'hFF)
      `CHK(bus_ready_int, 1'b0)
   endtask
   // writes held back by set select bits, released when they clear
   task automatic t_port6;
      apb(1'b1, port_pkg::port6_select_addr, 32'h0000_000F);
      `CHK(port6_pullup, 8'h00)
      `CHK(port2_pullup, 8'hFF)
      `CHK(port6_out, 8'hF3)
      apb(1'b1, port_pkg::port6_latch_addr, 32'h0000_005A);
      apb(1'b0, port_pkg::port6_latch_addr, 32'h0000_0000);
      `CHK(rd, 32'h0000_005F)
      `CHK(port6_out, 8'h53)
      apb(1'b0, port_pkg::status_addr, 32'h0000_0000);
      `CHK(rd, 32'h0000_0F01)
      apb(1'b1, port_pkg::port6_select_addr, 32'h0000_0000);
      apb(1'b0, port_pkg::port6_latch_addr, 32'h0000_0000);
      `CHK(rd, 32'h0000_005A)
      `CHK(port6_out, 8'h5A)
      apb(1'b0, port_pkg::status_addr, 32'h0000_0000);
      `CHK(rd, 32'h0000_0001)
      apb(1'b1, port_pkg::port6_open_drain_addr, 32'h0000_000C);
      `CHK(port6_oe, 8'hF7)
      apb(1'b0, port_pkg::port6_open_drain_addr, 32'h0000_0000);
      `CHK(rd, 32'h0000_000C)
      apb(1'b1, port_pkg::port6_open_drain_addr, 32'h0000_0000);
      `CHK(port6_oe, 8'hFF)
   endtask
   // unbonded bits store and read back; clock pin ignores open drain
   task automatic t_port2;
      apb(1'b1, port_pkg::port2_latch_addr, 32'h0000_00A8);
      apb(1'b0, port_pkg::port2_latch_addr, 32'h0000_0000);
      `CHK(rd, 32'h0000_00A8)
      apb(1'b1, port_pkg::port2_select_addr, 32'h0000_0028);
      apb(1'b0, port_pkg::port2_select_addr, 32'h0000_0000);
      `CHK(rd, 32'h0000_0028)
      `CHK(port2_pullup, 8'h00)
      apb(1'b1, port_pkg::port2_open_drain_addr, 32'h0000_00FF);
      apb(1'b0, port_pkg::port2_open_drain_addr, 32'h0000_0000);
      `CHK(rd, 32'h0000_00FF)
      repeat (2) begin
         @(negedge ref_clk);
         `CHK(port2_oe[7], 1'b1)
         `CHK(port2_out[7], core_clk_div)
      end
      // open drain set: unselected pins with a low latch bit and the clock pin stay driven
      `CHK(port2_oe, 8'hD7)
      @(posedge ref_clk);
      // unbonded pins parked as push-pull outputs with a fixed latch value
      apb(1'b1, port_pkg::port2_open_drain_addr, 32'h0000_0000);
      apb(1'b1, port_pkg::port2_select_addr, 32'h0000_0000);
      `CHK(port2_oe, 8'hFF)
      `CHK(port2_out[6:0], 7'h28)
      apb(1'b0, port_pkg::port2_pin_addr, 32'h0000_0000);
      `CHK(rd, 32'h0000_00A5)
      apb(1'b0, port_pkg::port6_pin_addr, 32'h0000_0000);
      `CHK(rd, 32'h0000_003C)
      apb(1'b0, 12'h030, 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
   endtask
   // ready pin reads low until switched to its bus function
   task automatic t_ready;
      int n;
      n = 0;
      `CHK(bus_ready_int, 1'b0)
      apb(1'b1, port_pkg::ready_select_addr, 32'h0000_0001);
      while (bus_ready_int !== 1'b1 && n < 10) begin
         n++;
         @(posedge ref_clk);
      end
      `CHK(bus_ready_int, 1'b1)
      // pin low passes three stages and must agree in stages two and three before it shows
      ready_pin_in <= 1'b0;
      repeat (3) @(negedge ref_clk);
      `CHK(bus_ready_int, 1'b1)
      repeat (2) @(negedge ref_clk);
      `CHK(bus_ready_int, 1'b0)
   endtask
   // watchdog far beyond the hundred or so cycles the tests need
   initial begin
      #100000;
      bad_count++;
      results();
   end
   initial begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      ready_pin_in = 1'b1;
      port2_in = 8'hA5;
      port6_in = 8'h3C;
      port6_func_out = 8'hC3;
      t_reset();
      repeat (7) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      repeat (5) @(posedge ref_clk);
      t_port6();
      t_port2();
      t_ready();
      results();
   end
endmodule
`default_nettype wire
